// ===== hdl/gcsd_top.sv
// gauge configuration bytes, derived settings and self-discharge scheduling
//
// Contract
// - high nibble of filter byte is activity threshold in 6 uV units
// - low nibble of filter byte is the self-discharge rate code
// - self-discharge steps only when not charging
// - programmed rate used as is from 20 to below 30 C
// - rate doubles per 10 C band hotter, capped at sixteen times
// - rate halves per 10 C band colder, floor at one quarter
// - each step subtracts nominal capacity count divided by 512
// - code 12 gives one step per 24 h, 12 h one band hotter
// - full charge uses taper byte times 192 plus cell voltage
// - stored gpio bit 0: enable cleared on reset, pin undriven output
// - stored gpio bit 1: enable set on reset, pin state readable; reset zeroes pack bit 7 too, so enable loads 0
// - pack bits 6 and 5 select charge termination voltage
// - codes 00..11 mean 3968, 4016, 4064, 4112 mV
// - fixed rate bit substitutes 0x42 for the rate compensation byte
// - with fixed rate bit set, byte 0x7e is ignored for gauging
// - fixed temp bit substitutes 0x7c for the temp compensation byte
// - with fixed temp bit set, byte 0x7f is ignored for gauging
`timescale 1ns/1ps
module gcsd_top #(
	parameter longint unsigned TICK_CYCLES = gcsd_pkg::SD_TICK_CYCLES
) (
	input  wire logic              clk_in,               // 50 MHz clock
	input  wire logic              rst_b_in,             // async reset, active low
	input  wire logic              wr_en_in,             // register write strobe
	input  wire logic              rd_en_in,             // register read strobe
	input  wire logic [7:0]        addr_in,              // register address
	input  wire logic [7:0]        wdata_in,             // write data
	input  wire logic signed [7:0] temp_c_in,            // cell temperature, deg C
	input  wire logic              charging_in,          // battery is charging
	input  wire logic [15:0]       nom_cap_in,           // nominal capacity count
	input  wire logic [15:0]       sense_mag_uv_in,      // sense voltage magnitude, uV
	input  wire logic [15:0]       charge_uv_in,         // charge sense voltage, uV
	input  wire logic [12:0]       cell_mv_in,           // cell voltage, mV
	input  wire logic              gpio_pin_in,          // gpio pin level
	output logic [7:0]             rdata_out,            // read data
	output logic                   rd_valid_out,         // read data valid pulse
	output logic                   activity_out,         // activity above filter
	output logic                   full_charge_out,      // full charge detected
	output logic [12:0]            term_mv_out,          // termination voltage, mV
	output logic [7:0]             rate_comp_coeffs_out, // effective rate comp byte
	output logic [7:0]             temp_comp_coeffs_out, // effective temp comp byte
	output logic                   gpio_input_enable_out,// gpio enable bit
	output logic                   gpio_pin_state_out,   // gpio pin state bit
	output logic                   gpio_out,             // gpio drive value
	output logic                   gpio_oe_out,          // gpio output enable
	output logic                   sd_step_out,          // self-discharge step pulse
	output logic [15:0]            sd_dec_out            // self-discharge amount
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic is_nvm(input logic [7:0] a);
		return (a >= gcsd_pkg::ADDR_NVM_LO) && (a <= gcsd_pkg::ADDR_NVM_HI);
	endfunction

	function automatic logic [12:0] term_mv(input logic [1:0] sel);
		logic [12:0] mv;
		unique case (sel)
			2'b00: mv = gcsd_pkg::TERM_MV_00;
			2'b01: mv = gcsd_pkg::TERM_MV_01;
			2'b10: mv = gcsd_pkg::TERM_MV_10;
			2'b11: mv = gcsd_pkg::TERM_MV_11;
		endcase
		return mv;
	endfunction

	// ----------------------------------------
	// stored bytes
	// ----------------------------------------
	logic [7:0] unlock_r;
	logic [7:0] filt_sd_r;
	logic [7:0] taper_r;
	logic [7:0] pack_cfg_r;
	logic [7:0] id3_r;
	logic [7:0] rate_comp_r;
	logic [7:0] temp_comp_r;
	logic       nvm_open;
	logic       cfg_wr;

	assign nvm_open = (unlock_r == gcsd_pkg::UNLOCK_KEY);
	assign cfg_wr   = wr_en_in && is_nvm(addr_in) && nvm_open;

	// key stays in force until overwritten
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			unlock_r <= gcsd_pkg::RST_UNLOCK;
		else if (wr_en_in && addr_in == gcsd_pkg::ADDR_UNLOCK)
			unlock_r <= wdata_in;
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			filt_sd_r   <= gcsd_pkg::RST_FILT_SD;
			taper_r     <= gcsd_pkg::RST_TAPER;
			pack_cfg_r  <= gcsd_pkg::RST_PACK_CFG;
			id3_r       <= gcsd_pkg::RST_ID3;
			rate_comp_r <= gcsd_pkg::RST_RATE_COMP;
			temp_comp_r <= gcsd_pkg::RST_TEMP_COMP;
		end else if (cfg_wr) begin
			unique case (addr_in)
				gcsd_pkg::ADDR_FILT_SD:   filt_sd_r   <= wdata_in;
				gcsd_pkg::ADDR_TAPER:     taper_r     <= wdata_in;
				gcsd_pkg::ADDR_PACK_CFG:  pack_cfg_r  <= wdata_in;
				gcsd_pkg::ADDR_ID3:       id3_r       <= wdata_in;
				gcsd_pkg::ADDR_RATE_COMP: rate_comp_r <= wdata_in;
				gcsd_pkg::ADDR_TEMP_COMP: temp_comp_r <= wdata_in;
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// read port
	// ----------------------------------------
	logic [7:0] rd_mux;

	always_comb begin
		unique case (addr_in)
			gcsd_pkg::ADDR_UNLOCK:    rd_mux = unlock_r;
			gcsd_pkg::ADDR_FILT_SD:   rd_mux = filt_sd_r;
			gcsd_pkg::ADDR_TAPER:     rd_mux = taper_r;
			gcsd_pkg::ADDR_PACK_CFG:  rd_mux = pack_cfg_r;
			gcsd_pkg::ADDR_ID3:       rd_mux = id3_r;
			gcsd_pkg::ADDR_RATE_COMP: rd_mux = rate_comp_r;
			gcsd_pkg::ADDR_TEMP_COMP: rd_mux = temp_comp_r;
			default:                  rd_mux = 8'h00;
		endcase
	end

	// stored bytes stay readable even when used as free id bytes
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rdata_out    <= 8'h00;
			rd_valid_out <= 1'b0;
		end else begin
			rd_valid_out <= rd_en_in;
			if (rd_en_in)
				rdata_out <= rd_mux;
		end
	end

	// ----------------------------------------
	// field decode
	// ----------------------------------------
	logic [3:0]  filt_code;
	logic [3:0]  sd_code;
	logic [15:0] filt_uv;
	logic [15:0] taper_uv;
	logic [12:0] term_sel_mv;

	assign filt_code   = filt_sd_r[gcsd_pkg::FILT_LSB +: 4];
	assign sd_code     = filt_sd_r[gcsd_pkg::SD_LSB +: 4];
	assign filt_uv     = 16'(filt_code) * 16'(gcsd_pkg::FILT_UV_PER_LSB);
	assign taper_uv    = 16'(taper_r) * 16'(gcsd_pkg::TAPER_UV_PER_LSB);
	// bits 4..2 of the pack byte are deliberately never decoded
	assign term_sel_mv = term_mv({pack_cfg_r[gcsd_pkg::PK_QV_HI_BIT],
		pack_cfg_r[gcsd_pkg::PK_QV_LO_BIT]});

	// ----------------------------------------
	// derived settings
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			term_mv_out <= gcsd_pkg::TERM_MV_00;
		else
			term_mv_out <= term_sel_mv;
	end

	// fixed bits hide the stored byte from gauging entirely
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rate_comp_coeffs_out <= gcsd_pkg::RST_RATE_COMP;
			temp_comp_coeffs_out <= gcsd_pkg::RST_TEMP_COMP;
		end else begin
			rate_comp_coeffs_out <= pack_cfg_r[gcsd_pkg::PK_RATE_FIX_BIT] ?
				gcsd_pkg::FIXED_RATE_COMP : rate_comp_r;
			temp_comp_coeffs_out <= pack_cfg_r[gcsd_pkg::PK_TEMP_FIX_BIT] ?
				gcsd_pkg::FIXED_TEMP_COMP : temp_comp_r;
		end
	end

	// ----------------------------------------
	// activity filter and full charge
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			activity_out <= 1'b0;
		else
			activity_out <= (sense_mag_uv_in >= filt_uv);
	end

	// taper compare is strict: at exactly the threshold charging continues
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			full_charge_out <= 1'b0;
		else
			full_charge_out <= charging_in && (cell_mv_in >= term_sel_mv)
				&& (charge_uv_in < taper_uv);
	end

	// ----------------------------------------
	// gpio power-up state
	// ----------------------------------------
	logic gpio_meta_r;
	logic gpio_sync_r;
	logic gpio_load_r;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			gpio_meta_r <= 1'b0;
			gpio_sync_r <= 1'b0;
		end else begin
			gpio_meta_r <= gpio_pin_in;
			gpio_sync_r <= gpio_meta_r;
		end
	end

	// stored bit is caught on the first edge after release, not under reset
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			gpio_load_r           <= 1'b1;
			gpio_input_enable_out <= 1'b0;
		end else if (gpio_load_r) begin
			gpio_load_r           <= 1'b0;
			gpio_input_enable_out <= pack_cfg_r[gcsd_pkg::PK_GPIO_BIT];
		end
	end

	// the pin is never driven here: undriven output or plain input
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			gpio_out           <= 1'b0;
			gpio_oe_out        <= 1'b0;
			gpio_pin_state_out <= 1'b0;
		end else begin
			gpio_out           <= 1'b0;
			gpio_oe_out        <= 1'b0;
			gpio_pin_state_out <= gpio_input_enable_out & gpio_sync_r;
		end
	end

	// ----------------------------------------
	// self-discharge scheduler
	// ----------------------------------------
	gcsd_sd_sched #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_sched (
		.clk_in       (clk_in),
		.rst_b_in     (rst_b_in),
		.rate_code_in (sd_code),
		.temp_c_in    (temp_c_in),
		.charging_in  (charging_in),
		.nom_cap_in   (nom_cap_in),
		.step_out     (sd_step_out),
		.dec_out      (sd_dec_out)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_unlock_gate: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		wr_en_in && unlock_r != 8'hdd |=>
		$stable({filt_sd_r, taper_r, pack_cfg_r, id3_r, rate_comp_r, temp_comp_r}))
		else $error("config byte written while locked");

	a_unlock_write: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		wr_en_in && addr_in == 8'h7a && unlock_r == 8'hdd |=> filt_sd_r == $past(wdata_in))
		else $error("unlocked write did not store");

	a_read_back: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		rd_en_in && addr_in == 8'h7a |=> rd_valid_out && rdata_out == $past(filt_sd_r))
		else $error("filter byte read back wrong");

	a_rate_comp_sel: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		pack_cfg_r[1] |=> rate_comp_coeffs_out == 8'h42)
		else $error("fixed rate compensation not applied");

	a_rate_comp_prog: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		!pack_cfg_r[1] |=> rate_comp_coeffs_out == $past(rate_comp_r))
		else $error("programmed rate compensation not used");

	a_rate_comp_free: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		pack_cfg_r[1] && $changed(rate_comp_r) |=> rate_comp_coeffs_out == 8'h42)
		else $error("id byte leaked into rate compensation");

	a_temp_comp_sel: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		!pack_cfg_r[0] |=> temp_comp_coeffs_out == $past(temp_comp_r))
		else $error("programmed temp compensation not used");

	a_temp_comp_fix: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		pack_cfg_r[0] |=> temp_comp_coeffs_out == 8'h7c)
		else $error("fixed temp compensation not applied");

	a_term_voltage: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		pack_cfg_r[6:5] == 2'b11 |=> term_mv_out == 13'd4112)
		else $error("termination voltage mismatch");

	a_term_lowest: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		pack_cfg_r[6:5] == 2'b00 |=> term_mv_out == 13'd3968)
		else $error("lowest termination voltage mismatch");

	a_activity_filt: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		sense_mag_uv_in < 16'(filt_sd_r[7:4]) * 16'd6 |=> !activity_out)
		else $error("activity below filter threshold");

	a_activity_above: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		sense_mag_uv_in >= 16'(filt_sd_r[7:4]) * 16'd6 |=> activity_out)
		else $error("activity at filter threshold missed");

	a_taper_full: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		full_charge_out |-> $past(charge_uv_in) < 16'($past(taper_r)) * 16'd192)
		else $error("full charge above taper current");

	a_full_voltage: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		full_charge_out |-> $past(charging_in) && $past(cell_mv_in) >= term_mv_out)
		else $error("full charge below termination voltage");

	a_gpio_reset: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		gpio_load_r |=> gpio_input_enable_out == $past(pack_cfg_r[7]))
		else $error("gpio enable not loaded from stored bit");

	a_gpio_state: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		!gpio_input_enable_out |=> !gpio_pin_state_out && !gpio_oe_out)
		else $error("gpio state visible while disabled");

	c_unlocked_wr: cover property (@(posedge clk_in) disable iff (!rst_b_in)
		cfg_wr && addr_in == gcsd_pkg::ADDR_PACK_CFG);
	c_sd_step: cover property (@(posedge clk_in) disable iff (!rst_b_in)
		sd_step_out);
	c_full_charge: cover property (@(posedge clk_in) disable iff (!rst_b_in)
		$rose(full_charge_out));
	c_fixed_both: cover property (@(posedge clk_in) disable iff (!rst_b_in)
		pack_cfg_r[1] && pack_cfg_r[0]);
	c_locked_wr: cover property (@(posedge clk_in) disable iff (!rst_b_in)
		wr_en_in && unlock_r != gcsd_pkg::UNLOCK_KEY);

endmodule

// ===== common/gcsd_pkg.sv
// shared constants for the gauge configuration decoder and self-discharge scheduler
package gcsd_pkg;

	// ----------------------------------------
	// register offsets and keys
	// ----------------------------------------
	localparam logic [7:0] ADDR_UNLOCK     = 8'h6e;
	localparam logic [7:0] ADDR_NVM_LO     = 8'h76;
	localparam logic [7:0] ADDR_NVM_HI     = 8'h7f;
	localparam logic [7:0] ADDR_FILT_SD    = 8'h7a;
	localparam logic [7:0] ADDR_TAPER      = 8'h7b;
	localparam logic [7:0] ADDR_PACK_CFG   = 8'h7c;
	localparam logic [7:0] ADDR_ID3        = 8'h7d;
	localparam logic [7:0] ADDR_RATE_COMP  = 8'h7e;
	localparam logic [7:0] ADDR_TEMP_COMP  = 8'h7f;
	localparam logic [7:0] UNLOCK_KEY      = 8'hdd;

	// ----------------------------------------
	// reset values of the stored bytes
	// ----------------------------------------
	localparam logic [7:0] RST_FILT_SD     = 8'h00;
	localparam logic [7:0] RST_TAPER       = 8'h00;
	localparam logic [7:0] RST_PACK_CFG    = 8'h00;
	localparam logic [7:0] RST_ID3         = 8'h00;
	localparam logic [7:0] RST_RATE_COMP   = 8'h00;
	localparam logic [7:0] RST_TEMP_COMP   = 8'h00;
	localparam logic [7:0] RST_UNLOCK      = 8'h00;

	// ----------------------------------------
	// field positions and decode constants
	// ----------------------------------------
	localparam int         FILT_LSB        = 4;
	localparam int         SD_LSB          = 0;
	localparam int         PK_GPIO_BIT     = 7;
	localparam int         PK_QV_HI_BIT    = 6;
	localparam int         PK_QV_LO_BIT    = 5;
	localparam int         PK_RATE_FIX_BIT = 1;
	localparam int         PK_TEMP_FIX_BIT = 0;
	localparam logic [7:0] FIXED_RATE_COMP = 8'h42;
	localparam logic [7:0] FIXED_TEMP_COMP = 8'h7c;
	localparam logic [7:0] FILT_UV_PER_LSB = 8'h06;
	localparam logic [7:0] TAPER_UV_PER_LSB = 8'hc0;
	localparam int         CAP_STEP_SHIFT  = 9;
	localparam logic [12:0] TERM_MV_00     = 13'hf80;
	localparam logic [12:0] TERM_MV_01     = 13'hfb0;
	localparam logic [12:0] TERM_MV_10     = 13'hfe0;
	localparam logic [12:0] TERM_MV_11     = 13'h1010;

	// ----------------------------------------
	// self-discharge temperature bands and timing
	// ----------------------------------------
	localparam logic signed [7:0] SD_REF_LO_C = 8'sh14;
	localparam logic signed [7:0] SD_BAND_C   = 8'sh0a;
	localparam logic [2:0] SD_SHIFT_REF    = 3'h4;
	localparam logic [2:0] SD_SHIFT_MAX    = 3'h6;
	localparam logic [2:0] SD_BANDS_HOT    = 3'h4;
	localparam longint unsigned CLK_HZ           = 64'd50_000_000;
	localparam longint unsigned SD_REF_CODE      = 64'd12;
	localparam longint unsigned SD_REF_INTERVAL_H = 64'd24;
	localparam longint unsigned SD_TICKS_PER_CODE = 64'd16;
	localparam longint unsigned SD_TICK_S =
		SD_REF_INTERVAL_H * 64'd3600 / (SD_REF_CODE * SD_TICKS_PER_CODE);
	localparam longint unsigned SD_TICK_CYCLES   = SD_TICK_S * CLK_HZ;
	localparam int              TICK_CNT_W       = 36;
	localparam int              INTV_CNT_W       = 11;

endpackage

// ===== hdl/gcsd_sd_sched.sv
// temperature-scaled self-discharge step scheduler
`timescale 1ns/1ps
module gcsd_sd_sched #(
	parameter longint unsigned TICK_CYCLES = gcsd_pkg::SD_TICK_CYCLES
) (
	input  wire logic              clk_in,        // 50 MHz clock
	input  wire logic              rst_b_in,      // async reset, active low
	input  wire logic [3:0]        rate_code_in,  // self-discharge rate code
	input  wire logic signed [7:0] temp_c_in,     // cell temperature, deg C
	input  wire logic              charging_in,   // battery is charging
	input  wire logic [15:0]       nom_cap_in,    // nominal capacity count
	output logic                   step_out,      // one-cycle reduction pulse
	output logic [15:0]            dec_out        // amount to subtract
);

	// ----------------------------------------
	// band decode
	// ----------------------------------------
	function automatic logic [2:0] band_shift(input logic signed [7:0] t);
		logic signed [7:0] lo;
		logic [2:0]        s;
		lo = gcsd_pkg::SD_REF_LO_C;
		s  = gcsd_pkg::SD_SHIFT_REF;
		for (int i = 1; i <= 4; i++) begin
			if (t >= lo + 8'(i) * gcsd_pkg::SD_BAND_C)
				s = gcsd_pkg::SD_SHIFT_REF - 3'(i);
		end
		if (t < lo)
			s = gcsd_pkg::SD_SHIFT_REF + 3'h1;
		if (t < lo - gcsd_pkg::SD_BAND_C)
			s = gcsd_pkg::SD_SHIFT_MAX;
		return s;
	endfunction

	logic [gcsd_pkg::TICK_CNT_W-1:0] tick_cnt_r;
	logic [gcsd_pkg::INTV_CNT_W-1:0] intv_cnt_r;
	logic [gcsd_pkg::INTV_CNT_W-1:0] target;
	logic                            tick;
	logic                            run;

	// interval in ticks = code << shift; shift 4 is the reference band
	assign target = gcsd_pkg::INTV_CNT_W'(rate_code_in) << band_shift(temp_c_in);
	assign run    = !charging_in && (rate_code_in != 4'h0);
	assign tick   = (tick_cnt_r == gcsd_pkg::TICK_CNT_W'(TICK_CYCLES - 64'd1));

	// ----------------------------------------
	// prescaler and interval counter
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			tick_cnt_r <= '0;
		else if (!run || tick)
			tick_cnt_r <= '0;
		else
			tick_cnt_r <= tick_cnt_r + 1'b1;
	end

	// frozen while charging so the elapsed share resumes afterwards
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			intv_cnt_r <= '0;
		else if (run && tick)
			intv_cnt_r <= (intv_cnt_r + 1'b1 >= target) ? '0 : intv_cnt_r + 1'b1;
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			step_out <= 1'b0;
			dec_out  <= '0;
		end else begin
			step_out <= run && tick && (intv_cnt_r + 1'b1 >= target);
			dec_out  <= nom_cap_in >> gcsd_pkg::CAP_STEP_SHIFT;
		end
	end

	a_sd_suspend: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		$past(charging_in) |-> !step_out)
		else $error("self-discharge step while charging");
	a_step_amount: assert property (@(posedge clk_in) disable iff (!rst_b_in)
		step_out |-> dec_out == ($past(nom_cap_in) >> 9))
		else $error("step amount is not capacity/512");

endmodule

// ===== verif/gcsd_host_model.sv
// host-side model that drives the configuration byte port
`timescale 1ns/1ps
module gcsd_host_model (
	input  wire logic       clk_in,      // device clock
	input  wire logic [7:0] rdata_in,    // read data from device
	input  wire logic       rd_valid_in, // read data valid
	output logic            wr_en_out,   // write strobe
	output logic            rd_en_out,   // read strobe
	output logic [7:0]      addr_out,    // register address
	output logic [7:0]      wdata_out    // write data
);
	initial begin
		wr_en_out = 1'b0;
		rd_en_out = 1'b0;
		addr_out = 8'h00;
		wdata_out = 8'h00;
	end

	// released lines show the inverse so stale values never look valid
	task automatic wr_raw(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		#1;
		wr_en_out = 1'b1;
		addr_out = a;
		wdata_out = d;
		@(posedge clk_in);
		#1;
		wr_en_out = 1'b0;
		addr_out = ~a;
		wdata_out = ~d;
	endtask

	// unlock every time: the key byte may have been overwritten meanwhile
	task automatic wr_cfg(input logic [7:0] a, input logic [7:0] d);
		wr_raw(gcsd_pkg::ADDR_UNLOCK, gcsd_pkg::UNLOCK_KEY);
		wr_raw(a, d);
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
		@(posedge clk_in);
		#1;
		rd_en_out = 1'b1;
		addr_out = a;
		@(posedge clk_in);
		#1;
		rd_en_out = 1'b0;
		addr_out = ~a;
		v = rd_valid_in;
		d = rdata_in;
	endtask
endmodule

// ===== verif/testbench.sv
// self-checking bench for the configuration decoder and self-discharge scheduler
`timescale 1ns/1ps
module testbench;
	localparam longint unsigned TICKS = 64'd2;
	logic               clk_in = 1'b0;
	logic               rst_b_in = 1'b0;
	logic               wr_en, rd_en, rd_valid, charging, gpio_pin, activity, full_chg;
	logic               gpio_ie, gpio_st, gpio_o, gpio_oe, sd_step, v;
	logic [7:0]         addr, wdata, rdata, rate_cc, temp_cc, d;
	logic signed [7:0]  temp_c;
	logic [15:0]        nom_cap, sense, chg_uv, sd_dec;
	logic [12:0]        cell_mv, term_mv;
	int                 failures = 0;
	int                 check_count = 0;
	int                 cycles = 0;
	int                 n, steps;
	int                 sd_code[11] = '{1, 1, 1, 1, 1, 1, 1, 1, 1, 12, 12};
	int                 sd_temp[11] = '{25, 20, 29, 30, 45, 55, 60, 19, 5, 25, 35};

	always #10 clk_in = ~clk_in;

	gcsd_host_model host (.clk_in(clk_in), .rdata_in(rdata), .rd_valid_in(rd_valid),
		.wr_en_out(wr_en), .rd_en_out(rd_en), .addr_out(addr), .wdata_out(wdata));

	gcsd_top #(.TICK_CYCLES(TICKS)) DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .wr_en_in(wr_en),
		.rd_en_in(rd_en), .addr_in(addr), .wdata_in(wdata), .temp_c_in(temp_c),
		.charging_in(charging), .nom_cap_in(nom_cap), .sense_mag_uv_in(sense), .charge_uv_in(chg_uv),
		.cell_mv_in(cell_mv), .gpio_pin_in(gpio_pin), .rdata_out(rdata), .rd_valid_out(rd_valid),
		.activity_out(activity), .full_charge_out(full_chg), .term_mv_out(term_mv),
		.rate_comp_coeffs_out(rate_cc), .temp_comp_coeffs_out(temp_cc),
		.gpio_input_enable_out(gpio_ie), .gpio_pin_state_out(gpio_st), .gpio_out(gpio_o),
		.gpio_oe_out(gpio_oe), .sd_step_out(sd_step), .sd_dec_out(sd_dec));

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
		host.rd(a, d, v);
		chk("rd_valid", 16'h0001, {15'h0000, v});
		chk("rdata", {8'h00, exp}, {8'h00, d});
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge clk_in);
		#1;
	endtask

	// cycles from here to the next step pulse, bounded
	task automatic gap(output int k);
		k = 0;
		do begin
			tick(1);
			k++;
		end while (sd_step !== 1'b1 && k < 3000);
	endtask

	// expected interval from the temperature band, worked out independently
	function automatic int sd_interval(input int code, input int t);
		int base;
		base = code * int'(gcsd_pkg::SD_TICKS_PER_CODE) * int'(TICKS);
		if (t >= 30) base = base >> (((t - 20) / 10 > 4) ? 4 : (t - 20) / 10);
		if (t < 20) base = base << (((29 - t) / 10 > 2) ? 2 : (29 - t) / 10);
		return base;
	endfunction

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ceiling well above the few thousand cycles the tests need
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 40000) begin
			failures++;
			$display("[ERR] timeout expected done seen running");
			tally_and_finish();
		end
	end

	initial begin
		temp_c = 8'sh19;
		charging = 1'b0;
		nom_cap = 16'habcd;
		sense = 16'h0000;
		chg_uv = 16'h0000;
		cell_mv = 13'h0000;
		gpio_pin = 1'b1;
		tick(12);
		rst_b_in = 1'b1;
		tick(2);
		// reset state: stored bytes zero, pin undriven
		for (int a = 8'h7a; a <= 8'h7f; a++) chk_rd(a[7:0], 8'h00);
		chk("term_mv", 16'h0f80, {3'h0, term_mv});
		chk("gpio_ie", 16'h0000, {15'h0, gpio_ie});
		chk("gpio_st", 16'h0000, {15'h0, gpio_st});
		chk("gpio_oe", 16'h0000, {15'h0, gpio_oe});
		chk("gpio_out", 16'h0000, {15'h0, gpio_o});
		$display("test reset done");
		// locked, unmapped and reserved writes are dropped
		host.wr_raw(8'h7a, 8'h55);
		chk_rd(8'h7a, 8'h00);
		host.wr_raw(8'h20, 8'h99);
		chk_rd(8'h20, 8'h00);
		host.wr_cfg(8'h76, 8'h99);
		chk_rd(8'h76, 8'h00);
		host.wr_cfg(8'h7b, 8'h02);
		chk_rd(8'h7b, 8'h02);
		$display("test access done");
		// termination select with the unused bits set
		for (int i = 0; i < 4; i++) begin
			host.wr_cfg(8'h7c, {1'b0, i[1:0], 5'b11100});
			tick(2);
			chk("term_mv", 16'(3968 + 48 * i), {3'h0, term_mv});
		end
		host.wr_cfg(8'h7e, 8'h11);
		host.wr_cfg(8'h7f, 8'h22);
		for (int i = 0; i < 4; i++) begin
			host.wr_cfg(8'h7c, {6'h00, i[1:0]});
			tick(2);
			chk("rate_comp", i[1] ? 16'h0042 : 16'h0011, {8'h00, rate_cc});
			chk("temp_comp", i[0] ? 16'h007c : 16'h0022, {8'h00, temp_cc});
		end
		chk_rd(8'h7e, 8'h11);
		$display("test pack done");
		// filter threshold 3 codes = 18 uV
		host.wr_cfg(8'h7a, 8'h30);
		sense = 16'd17;
		tick(3);
		chk("activity", 16'h0000, {15'h0, activity});
		sense = 16'd18;
		tick(3);
		chk("activity", 16'h0001, {15'h0, activity});
		$display("test filter done");
		// self-discharge intervals per band; first two steps settle the schedule
		for (int r = 0; r < 11; r++) begin
			host.wr_cfg(8'h7a, {4'h3, 4'(sd_code[r])});
			temp_c = 8'(sd_temp[r]);
			gap(n);
			gap(n);
			gap(n);
			chk("interval", 16'(sd_interval(sd_code[r], sd_temp[r])), 16'(n));
			chk("sd_dec", 16'h0055, sd_dec);
		end
		charging = 1'b1;
		steps = 0;
		repeat (600) begin
			tick(1);
			if (sd_step === 1'b1) steps++;
		end
		chk("steps_charging", 16'h0000, 16'(steps));
		charging = 1'b0;
		gap(n);
		chk("step_resumes", 16'h0001, {15'h0, n < 3000});
		$display("test selfdischarge done");
		// taper byte 2 gives 384 uV, pack code 00 gives 3968 mV
		charging = 1'b1;
		cell_mv = 13'd3968;
		chg_uv = 16'd383;
		tick(3);
		chk("full_charge", 16'h0001, {15'h0, full_chg});
		chg_uv = 16'd384;
		tick(3);
		chk("full_charge", 16'h0000, {15'h0, full_chg});
		chg_uv = 16'd383;
		cell_mv = 13'd3967;
		tick(3);
		chk("full_charge", 16'h0000, {15'h0, full_chg});
		$display("test taper done");
		tally_and_finish();
	end
endmodule
